// file: hw/rtcot_map.vh
// Constants for the requester tag, credit and order tracker
`ifndef RTCOT_MAP_VH
`define RTCOT_MAP_VH
// ==========================================================
// Register offsets (byte addresses)
`define RTCOT_CTRL_OFS 4'h0
`define RTCOT_NPH_OFS 4'h4
`define RTCOT_NPD_OFS 4'h8
`define RTCOT_STATUS_OFS 4'hC
// ==========================================================
// Control fields
`define RTCOT_CTRL_CLIENT_BIT 0
`define RTCOT_CTRL_STRADDLE_BIT 1
`define RTCOT_CTRL_FCSEL_LSB 2
`define RTCOT_CTRL_FCSEL_MSB 4
`define RTCOT_FCSEL_TX_AVAIL 3'h4
// ==========================================================
// Status fields
`define RTCOT_STAT_OUTST_LSB 0
`define RTCOT_STAT_OUTST_MSB 8
`define RTCOT_STAT_FREE_LSB 16
`define RTCOT_STAT_FREE_MSB 24
// ==========================================================
// Reset values
`define RTCOT_CTRL_RST 5'h00
`define RTCOT_NPH_RST 8'h00
`define RTCOT_NPD_RST 12'h000
// ==========================================================
// Table and report sizes
`define RTCOT_TABLE_DEPTH 9'h100
`define RTCOT_SAT_MAX 4'hF
`endif

// file: hw/rtcot_tracker.v
// Requester tag allocation, credit reporting and posted order tracking
//
// Function
// R1: Track up to 256 outstanding non-posted requests by 8-bit tag.
// R2: Client tag off: pick free tag per non-posted request, output it.
// R3: User records each reported tag to match later completions.
// R4: Internal tags: drop ready when outstanding count reaches table limit.
// R5: Client tag on: user picks unique tags inside the descriptor.
// R6: Client tag on: still record and match, no uniqueness or full check.
// R7: Internal tags: one-cycle tag-valid pulse with tag already present.
// R8: Two tags together: earlier request on output a, later on b.
// R9: Valid b never without valid a; lone tag always on a.
// R10: Straddle off: one tag per cycle, valid b stays low.
// R11: Tags come later but in request order; user pairs them FIFO.
// R12: Stall non-posted request while credit or free tag is lacking.
// R13: Four-bit header credit count, saturating at fifteen.
// R14: Four-bit data credit count, saturating at fifteen.
// R15: Four-bit free tag count, saturating at fifteen.
// R16: Counts lag two cycles behind request; user deducts recent requests.
// R17: User stops non-posted requests at zero credit, else counts drift.
// R18: Credit counts also on config outputs when selector is transmit view.
// R19: Requests leave in exactly their acceptance order.
// R20: User supplies optional 6-bit posted sequence numbers per start slot.
// R21: Pulse sequence valid a, then b, when posted request passes stage.
// R22: Completions sent after report cannot overtake that posted request.
// R23: Client tags are not reused before the completed indication.
// R24: Free a tag on its final completion and update free count.
`include "rtcot_map.vh"

module rtcot_tracker #(
  parameter TAG_W = 8,
  parameter SEQ_W = 6,
  parameter NPH_W = 8,
  parameter NPD_W = 12
) (
  input wire ref_clk_i,
  input wire resetn_i,
  // ==========================================================
  // Register port
  input wire [3:0] reg_addr_i,
  input wire [31:0] reg_wdata_i,
  input wire reg_wr_i,
  input wire reg_rd_i,
  output reg [31:0] reg_rdata_o,
  // ==========================================================
  // Request stream, decoded per beat
  input wire req_valid_i,
  output reg request_stream_ready_o,
  input wire req_start_a_i,
  input wire req_start_b_i,
  input wire req_np_a_i,
  input wire req_np_b_i,
  input wire req_np_data_a_i,
  input wire req_np_data_b_i,
  input wire [TAG_W-1:0] client_tag_a_i,
  input wire [TAG_W-1:0] client_tag_b_i,
  input wire [SEQ_W-1:0] posted_seq_in_a_i,
  input wire [SEQ_W-1:0] posted_seq_in_b_i,
  // ==========================================================
  // Completion and credit return
  input wire cpl_valid_i,
  input wire [TAG_W-1:0] cpl_tag_i,
  input wire cpl_done_i,
  input wire nph_return_i,
  input wire npd_return_i,
  // ==========================================================
  // Reports
  output reg [TAG_W-1:0] alloc_tag_out_a_o,
  output reg [TAG_W-1:0] alloc_tag_out_b_o,
  output reg alloc_tag_valid_a_o,
  output reg alloc_tag_valid_b_o,
  output reg [3:0] np_header_credit_avail_o,
  output reg [3:0] np_data_credit_avail_o,
  output reg [3:0] free_tag_count_o,
  output reg [SEQ_W-1:0] posted_seq_out_a_o,
  output reg [SEQ_W-1:0] posted_seq_out_b_o,
  output reg posted_seq_valid_a_o,
  output reg posted_seq_valid_b_o,
  output reg [NPH_W-1:0] cfg_np_header_credit_o,
  output reg [NPD_W-1:0] cfg_np_data_credit_o
);

  localparam DEPTH = 256;

  // ==========================================================
  // Functions
  // Lowest free index wins; the second pick skips the first
  function [8:0] find_free;
    input [DEPTH-1:0] map;
    input skip_en;
    input [7:0] skip;
    integer i;
    begin
      find_free = 9'h000;
      for (i = DEPTH - 1; i >= 0; i = i - 1) begin
        if (!map[i] && !(skip_en && (skip == i[7:0]))) begin
          find_free = {1'b1, i[7:0]};
        end
      end
    end
  endfunction

  // Shared decode of a register write hit
  function wr_hit;
    input [3:0] addr;
    input [3:0] ofs;
    input wr;
    begin
      wr_hit = wr && (addr == ofs);
    end
  endfunction

  // Set bits of the busy map
  function [8:0] pop_count;
    input [DEPTH-1:0] map;
    integer i;
    begin
      pop_count = 9'h000;
      for (i = 0; i < DEPTH; i = i + 1) begin
        pop_count = pop_count + {8'h00, map[i]};
      end
    end
  endfunction

  // Clamp to the four-bit report range
  function [3:0] sat4;
    input [11:0] val;
    begin
      if (val > {8'h00, `RTCOT_SAT_MAX}) begin
        sat4 = `RTCOT_SAT_MAX;
      end else begin
        sat4 = val[3:0];
      end
    end
  endfunction

  // ==========================================================
  // State
  reg [4:0] ctrl;
  reg [NPH_W-1:0] nph_cnt;
  reg [NPD_W-1:0] npd_cnt;
  reg [DEPTH-1:0] busy;
  reg [8:0] outstanding;
  reg seq_v_a;
  reg seq_v_b;
  reg [SEQ_W-1:0] seq_n_a;
  reg [SEQ_W-1:0] seq_n_b;

  wire client_mode = ctrl[`RTCOT_CTRL_CLIENT_BIT];
  wire straddle = ctrl[`RTCOT_CTRL_STRADDLE_BIT];
  wire [2:0] fc_sel = ctrl[`RTCOT_CTRL_FCSEL_MSB:`RTCOT_CTRL_FCSEL_LSB];

  // ==========================================================
  // Acceptance and allocation
  // Per-slot decode of the accepted beat
  reg accept;
  reg np_a;
  reg np_b;
  reg pst_a;
  reg pst_b;
  reg [1:0] n_np;
  reg [1:0] n_npd;

  // Tag picks
  reg [8:0] free0;
  reg [8:0] free1;
  reg [7:0] tag_first;
  reg [7:0] tag_second;

  // Next values
  reg [DEPTH-1:0] next_busy;
  reg [8:0] next_outstanding;
  reg [NPH_W-1:0] next_nph;
  reg [NPD_W-1:0] next_npd;
  reg [1:0] need;
  reg next_ready;

  always @* begin
    accept = req_valid_i & request_stream_ready_o;
    np_a = accept & req_start_a_i & req_np_a_i;
    // Second slot only exists with straddle on
    np_b = accept & straddle & req_start_b_i & req_np_b_i; // R10
    pst_a = accept & req_start_a_i & ~req_np_a_i;
    pst_b = accept & straddle & req_start_b_i & ~req_np_b_i;
    n_np = {1'b0, np_a} + {1'b0, np_b};
    n_npd = {1'b0, np_a & req_np_data_a_i} + {1'b0, np_b & req_np_data_b_i};
  end

  // ==========================================================
  // Tag choice
  always @* begin
    free0 = find_free(busy, 1'b0, 8'h00); // R2
    free1 = find_free(busy, 1'b1, free0[7:0]);
    if (client_mode) begin
      // No uniqueness check on user tags
      tag_first = np_a ? client_tag_a_i : client_tag_b_i; // R6
      tag_second = client_tag_b_i;
    end else begin
      tag_first = free0[7:0];
      tag_second = free1[7:0];
    end
  end

  // ==========================================================
  // Table update
  always @* begin
    next_busy = busy;
    // Release first so a same-cycle allocation of that tag wins
    if (cpl_valid_i && cpl_done_i) begin
      next_busy[cpl_tag_i] = 1'b0; // R24
    end
    if (np_a || np_b) begin
      next_busy[tag_first] = 1'b1; // R1
    end
    if (np_a && np_b) begin
      next_busy[tag_second] = 1'b1;
    end
    next_outstanding = pop_count(next_busy);
  end

  // ==========================================================
  // Credit counters
  always @* begin
    next_nph = nph_cnt - {{(NPH_W-2){1'b0}}, n_np} // R17
      + {{(NPH_W-1){1'b0}}, nph_return_i};
    next_npd = npd_cnt - {{(NPD_W-2){1'b0}}, n_npd}
      + {{(NPD_W-1){1'b0}}, npd_return_i};
    if (wr_hit(reg_addr_i, `RTCOT_NPH_OFS, reg_wr_i)) begin
      next_nph = reg_wdata_i[NPH_W-1:0];
    end
    if (wr_hit(reg_addr_i, `RTCOT_NPD_OFS, reg_wr_i)) begin
      next_npd = reg_wdata_i[NPD_W-1:0];
    end
  end

  // ==========================================================
  // Stream ready
  always @* begin
    // Ready is registered, so it must cover a worst-case next beat;
    // this can stall one cycle early but never overcommits.
    need = straddle ? 2'h2 : 2'h1;
    next_ready = 1'b1;
    if (next_nph < {{(NPH_W-2){1'b0}}, need} ||
        next_npd < {{(NPD_W-2){1'b0}}, need}) begin
      next_ready = 1'b0; // R12
    end
    if (!client_mode &&
        next_outstanding + {7'h00, need} > `RTCOT_TABLE_DEPTH) begin
      next_ready = 1'b0; // R4
    end
  end

  // ==========================================================
  // Registers and bookkeeping
  always @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      ctrl <= `RTCOT_CTRL_RST;
      nph_cnt <= `RTCOT_NPH_RST;
      npd_cnt <= `RTCOT_NPD_RST;
      busy <= {DEPTH{1'b0}};
      outstanding <= 9'h000;
      request_stream_ready_o <= 1'b0;
    end else begin
      if (wr_hit(reg_addr_i, `RTCOT_CTRL_OFS, reg_wr_i)) begin
        ctrl <= reg_wdata_i[4:0];
      end
      nph_cnt <= next_nph;
      npd_cnt <= next_npd;
      busy <= next_busy;
      outstanding <= next_outstanding;
      request_stream_ready_o <= next_ready;
    end
  end

  // ==========================================================
  // Read port: data stand in the cycle after the strobe, else zero
  always @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      reg_rdata_o <= 32'h00000000;
    end else begin
      reg_rdata_o <= 32'h00000000;
      if (reg_rd_i) begin
        case (reg_addr_i)
          `RTCOT_CTRL_OFS: reg_rdata_o <= {27'h0000000, ctrl};
          `RTCOT_NPH_OFS: reg_rdata_o <= {{(32-NPH_W){1'b0}}, nph_cnt};
          `RTCOT_NPD_OFS: reg_rdata_o <= {{(32-NPD_W){1'b0}}, npd_cnt};
          `RTCOT_STATUS_OFS: begin
            reg_rdata_o[`RTCOT_STAT_OUTST_MSB:`RTCOT_STAT_OUTST_LSB]
              <= outstanding;
            reg_rdata_o[`RTCOT_STAT_FREE_MSB:`RTCOT_STAT_FREE_LSB]
              <= `RTCOT_TABLE_DEPTH - outstanding;
          end
          default: reg_rdata_o <= 32'h00000000;
        endcase
      end
    end
  end

  // ==========================================================
  // Tag report, one cycle after acceptance, in request order
  always @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      alloc_tag_out_a_o <= {TAG_W{1'b0}};
      alloc_tag_out_b_o <= {TAG_W{1'b0}};
      alloc_tag_valid_a_o <= 1'b0;
      alloc_tag_valid_b_o <= 1'b0;
    end else begin
      alloc_tag_out_a_o <= tag_first; // R8
      alloc_tag_out_b_o <= tag_second;
      alloc_tag_valid_a_o <= ~client_mode & (np_a | np_b); // R7 R9 R11
      alloc_tag_valid_b_o <= ~client_mode & np_a & np_b; // R8 R9
    end
  end

  // ==========================================================
  // Counts: counter updates on edge one, report on edge two
  always @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      np_header_credit_avail_o <= 4'h0;
      np_data_credit_avail_o <= 4'h0;
      free_tag_count_o <= 4'h0;
    end else begin
      np_header_credit_avail_o <= sat4({4'h0, nph_cnt}); // R13 R16
      np_data_credit_avail_o <= sat4(npd_cnt); // R14 R16
      free_tag_count_o <=
        sat4({3'h0, `RTCOT_TABLE_DEPTH - outstanding}); // R15 R16
    end
  end

  // ==========================================================
  // Flow-control view of the raw counters
  always @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      cfg_np_header_credit_o <= {NPH_W{1'b0}};
      cfg_np_data_credit_o <= {NPD_W{1'b0}};
    end else begin
      if (fc_sel == `RTCOT_FCSEL_TX_AVAIL) begin
        cfg_np_header_credit_o <= nph_cnt; // R18
        cfg_np_data_credit_o <= npd_cnt; // R18
      end else begin
        cfg_np_header_credit_o <= {NPH_W{1'b0}};
        cfg_np_data_credit_o <= {NPD_W{1'b0}};
      end
    end
  end

  // ==========================================================
  // Posted order: single in-order pipe, reported at its last stage;
  // completions merge only after this stage so they cannot pass.
  always @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      seq_v_a <= 1'b0;
      seq_v_b <= 1'b0;
      seq_n_a <= {SEQ_W{1'b0}};
      seq_n_b <= {SEQ_W{1'b0}};
    end else begin
      seq_v_a <= pst_a | pst_b; // R19
      seq_v_b <= pst_a & pst_b;
      seq_n_a <= pst_a ? posted_seq_in_a_i : posted_seq_in_b_i;
      seq_n_b <= posted_seq_in_b_i;
    end
  end

  // ==========================================================
  // Report stage: the point that completions cannot pass
  always @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      posted_seq_out_a_o <= {SEQ_W{1'b0}};
      posted_seq_out_b_o <= {SEQ_W{1'b0}};
      posted_seq_valid_a_o <= 1'b0;
      posted_seq_valid_b_o <= 1'b0;
    end else begin
      posted_seq_valid_a_o <= seq_v_a; // R21 R22
      posted_seq_valid_b_o <= seq_v_b; // R21
      posted_seq_out_a_o <= seq_n_a;
      posted_seq_out_b_o <= seq_n_b;
    end
  end

endmodule // rtcot_tracker

// file: tb/rtcot_chk.sv
// Port-level assertions for the requester tag, credit and order tracker
`include "rtcot_map.vh"
module rtcot_chk (
  input wire ref_clk_i,
  input wire resetn_i,
  input wire [3:0] reg_addr_i,
  input wire [31:0] reg_wdata_i,
  input wire reg_wr_i,
  input wire req_valid_i,
  input wire request_stream_ready_o,
  input wire req_start_a_i,
  input wire req_start_b_i,
  input wire req_np_a_i,
  input wire req_np_b_i,
  input wire cpl_valid_i,
  input wire nph_return_i,
  input wire alloc_tag_valid_a_o,
  input wire alloc_tag_valid_b_o,
  input wire [7:0] alloc_tag_out_a_o,
  input wire [7:0] alloc_tag_out_b_o,
  input wire posted_seq_valid_a_o,
  input wire [3:0] np_header_credit_avail_o,
  input wire [3:0] free_tag_count_o
);
  // ==========================================================
  // Mirror of the mode bits, so pulses can be tied to their cause
  reg client;
  reg strad;
  wire acc = req_valid_i & request_stream_ready_o;
  wire np_a = acc & req_start_a_i & req_np_a_i;
  wire np_b = acc & req_start_b_i & req_np_b_i & strad;
  wire po = acc & (req_start_a_i & !req_np_a_i |
    req_start_b_i & !req_np_b_i & strad);
  always @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      client <= 1'b0;
      strad <= 1'b0;
    end else if (reg_wr_i && reg_addr_i == `RTCOT_CTRL_OFS) begin
      client <= reg_wdata_i[`RTCOT_CTRL_CLIENT_BIT];
      strad <= reg_wdata_i[`RTCOT_CTRL_STRADDLE_BIT];
    end
  end
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!resetn_i);
  // ==========================================================
  // Assertions
  chk_tag_pulse_cause: assert property (alloc_tag_valid_a_o ==
    ($past(np_a | np_b) && !$past(client))) else $error("tag valid a");
  chk_b_needs_a: assert property (alloc_tag_valid_b_o
    |-> alloc_tag_valid_a_o) else $error("tag valid b alone");
  chk_b_two_np: assert property (alloc_tag_valid_b_o ==
    ($past(np_a && np_b) && !$past(client))) else $error("tag valid b");
  chk_single_tag: assert property (!strad
    |-> !alloc_tag_valid_b_o) else $error("tag b without straddle");
  chk_tags_differ: assert property (alloc_tag_valid_b_o
    |-> alloc_tag_out_a_o != alloc_tag_out_b_o) else $error("same tags");
  chk_seq_report: assert property (posted_seq_valid_a_o ==
    $past(po, 2)) else $error("sequence valid timing");
  chk_free_hold: assert property (!$past(acc, 2) &&
    !$past(cpl_valid_i, 2) && $past(resetn_i, 3)
    |-> $stable(free_tag_count_o)) else $error("free count moved");
  chk_hdr_hold: assert property (!$past(acc, 2) &&
    !$past(nph_return_i, 2) && !$past(reg_wr_i, 2) && $past(resetn_i, 3)
    |-> $stable(np_header_credit_avail_o)) else $error("credit moved");
endmodule // rtcot_chk

bind rtcot_tracker rtcot_chk rtcot_chk_i (.*);

// file: tb/rtcot_user.sv
// User-side request model: offers requests and queues reported tags
module rtcot_user (
  input wire ref_clk_i,
  input wire resetn_i,
  input wire go_i,
  input wire [16:0] cmd_i,
  input wire ready_i,
  input wire tva_i,
  input wire tvb_i,
  input wire [7:0] ta_i,
  input wire [7:0] tb_i,
  output logic req_valid_o,
  output wire start_b_o,
  output wire [15:0] pay_o
);
  logic [16:0] cmd;
  logic [7:0] tags [$];
  assign start_b_o = cmd[16];
  assign pay_o = cmd[15:0];
  // ==========================================================
  // Request hold: nothing moves until the beat is taken
  always @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      req_valid_o <= 1'b0;
      cmd <= 17'h00000;
    end else if (req_valid_o && ready_i) begin
      req_valid_o <= 1'b0;
      cmd <= ~cmd; // Released fields must not look still valid
    end else if (go_i && !req_valid_o) begin
      req_valid_o <= 1'b1;
      cmd <= cmd_i;
    end
  end
  // Tags are kept in arrival order, output a before b
  always @(posedge ref_clk_i) begin
    if (tva_i) tags.push_back(ta_i);
    if (tvb_i) tags.push_back(tb_i);
  end
endmodule // rtcot_user

// file: tb/tb_rtcot_tracker.sv
// Self-checking bench for the requester tag, credit and order tracker
`include "rtcot_map.vh"
module tb_rtcot_tracker;
  timeunit 1ns;
  timeprecision 100ps;
  logic ref_clk_i = 0, resetn_i = 0, reg_wr_i = 0, reg_rd_i = 0, go = 0;
  logic cpl_valid_i = 0, cpl_done_i = 0, nph_return_i = 0, npd_return_i = 0;
  logic [3:0] reg_addr_i = 4'h0;
  logic [31:0] reg_wdata_i = 32'h0;
  logic [7:0] cpl_tag_i = 8'h00;
  logic [16:0] cmd = 17'h00000;
  wire [31:0] reg_rdata_o;
  wire [15:0] pay;
  wire rv, sb, request_stream_ready_o, alloc_tag_valid_a_o;
  wire alloc_tag_valid_b_o, posted_seq_valid_a_o, posted_seq_valid_b_o;
  wire [7:0] alloc_tag_out_a_o, alloc_tag_out_b_o, cfg_np_header_credit_o;
  wire [3:0] np_header_credit_avail_o, np_data_credit_avail_o;
  wire [3:0] free_tag_count_o;
  wire [5:0] posted_seq_out_a_o, posted_seq_out_b_o;
  wire [11:0] cfg_np_data_credit_o;
  logic [5:0] seq_seen = 6'h00, seq_seen_b = 6'h00;
  logic [7:0] exp_tags [6] = '{8'h00, 8'h01, 8'h02, 8'h01, 8'h03, 8'h04};
  int errors = 0, checks_done = 0, cyc = 0, i;
  rtcot_tracker rtcot_tracker_i (.*, .req_valid_i(rv), .req_start_a_i(rv),
    .req_start_b_i(sb), .req_np_a_i(pay[15]), .req_np_b_i(pay[15]),
    .req_np_data_a_i(pay[14]), .req_np_data_b_i(pay[14]),
    .client_tag_a_i(pay[7:0]), .client_tag_b_i(8'h00),
    .posted_seq_in_a_i(pay[13:8]), .posted_seq_in_b_i(pay[5:0]));
  rtcot_user rtcot_user_i (.ref_clk_i(ref_clk_i), .resetn_i(resetn_i),
    .go_i(go), .cmd_i(cmd), .ready_i(request_stream_ready_o),
    .tva_i(alloc_tag_valid_a_o), .tvb_i(alloc_tag_valid_b_o),
    .ta_i(alloc_tag_out_a_o), .tb_i(alloc_tag_out_b_o),
    .req_valid_o(rv), .start_b_o(sb), .pay_o(pay));
  // ==========================================================
  // Tasks
  task chk(input [31:0] got, input [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      errors++;
      $display("FAIL %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task end_of_test;
    $display("checks %0d errors %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task wr(input [3:0] a, input [31:0] d);
    @(posedge ref_clk_i);
    {reg_wr_i, reg_addr_i, reg_wdata_i} <= {1'b1, a, d};
    @(posedge ref_clk_i);
    reg_wr_i <= 1'b0;
  endtask
  task rd(input [3:0] a, input [31:0] e);
    @(posedge ref_clk_i);
    {reg_rd_i, reg_addr_i} <= {1'b1, a};
    @(posedge ref_clk_i);
    reg_rd_i <= 1'b0;
    #1 chk(reg_rdata_o, e);
  endtask
  // Waits for acceptance, then lets the counts settle past their lag
  task send(input [16:0] c);
    @(posedge ref_clk_i);
    {go, cmd} <= {1'b1, c};
    @(posedge ref_clk_i);
    go <= 1'b0;
    #1 while (rv) @(posedge ref_clk_i) #1;
    repeat (3) @(posedge ref_clk_i);
    #1;
  endtask
  task cpl(input [7:0] t);
    @(posedge ref_clk_i);
    {cpl_valid_i, cpl_done_i, cpl_tag_i} <= {2'b11, t};
    @(posedge ref_clk_i);
    {cpl_valid_i, cpl_done_i} <= 2'b00;
  endtask
  // ==========================================================
  // Clock, timeout and sequence monitor
  always #5 ref_clk_i = ~ref_clk_i;
  always @(posedge ref_clk_i) begin
    cyc <= cyc + 1;
    if (posted_seq_valid_a_o) seq_seen <= posted_seq_out_a_o;
    if (posted_seq_valid_b_o) seq_seen_b <= posted_seq_out_b_o;
    if (cyc == 3000) begin
      errors++;
      end_of_test;
    end
  end
  // ==========================================================
  // Tests
  initial begin
    repeat (6) @(posedge ref_clk_i);
    resetn_i <= 1'b1;
    rd(`RTCOT_STATUS_OFS, 32'h01000000);
    rd(`RTCOT_CTRL_OFS, 32'h00000000);
    rd(4'h2, 32'h00000000);
    wr(`RTCOT_NPH_OFS, 32'h00000003);
    wr(`RTCOT_NPD_OFS, 32'h00000001);
    rd(`RTCOT_NPH_OFS, 32'h00000003);
    send(17'h0C000);
    chk(np_header_credit_avail_o, 4'h2);
    chk(np_data_credit_avail_o, 4'h0);
    chk(request_stream_ready_o, 1'b0);
    @(posedge ref_clk_i);
    npd_return_i <= 1'b1;
    @(posedge ref_clk_i);
    npd_return_i <= 1'b0;
    send(17'h08000);
    send(17'h08000);
    chk(np_header_credit_avail_o, 4'h0);
    chk(request_stream_ready_o, 1'b0);
    chk(free_tag_count_o, 4'hF);
    rd(`RTCOT_STATUS_OFS, 32'h00FD0003);
    cpl(8'h01);
    rd(`RTCOT_STATUS_OFS, 32'h00FE0002);
    wr(`RTCOT_NPH_OFS, 32'h00000005);
    send(17'h08000);
    send(17'h02A00);
    chk(seq_seen, 6'h2A);
    chk(np_header_credit_avail_o, 4'h4);
    wr(`RTCOT_CTRL_OFS, 32'h00000012);
    wr(`RTCOT_NPD_OFS, 32'h00000002);
    send(17'h18000);
    chk(cfg_np_header_credit_o, 8'h02);
    chk(cfg_np_data_credit_o, 12'h002);
    wr(`RTCOT_CTRL_OFS, 32'h00000001);
    send(17'h08080);
    rd(`RTCOT_STATUS_OFS, 32'h00FA0006);
    cpl(8'h80);
    rd(`RTCOT_STATUS_OFS, 32'h00FB0005);
    wr(`RTCOT_CTRL_OFS, 32'h00000002);
    wr(`RTCOT_NPH_OFS, 32'h00000005);
    send(17'h11115);
    chk(seq_seen, 6'h11);
    chk(seq_seen_b, 6'h15);
    chk(rtcot_user_i.tags.size(), 6);
    for (i = 0; i < 6; i++) chk(rtcot_user_i.tags[i], exp_tags[i]);
    end_of_test;
  end
endmodule // tb_rtcot_tracker
